// [design/bbrs_top.sv]
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bbrs_top #(
	parameter int GAIN_W = 7
) (
	// Clock and reset
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [bbrs_pkg::ADDR_W-1:0]    paddr,
	input  wire logic [bbrs_pkg::DATA_W-1:0]    pwdata,
	output logic      [bbrs_pkg::DATA_W-1:0]    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// Header CRC from the receiver
	input  wire logic                           hdr_crc_valid,
	input  wire logic [15:0]                    hdr_crc,
	// Measurements
	input  wire logic                           tx_power_valid,
	input  wire logic [7:0]                     tx_power,
	input  wire logic [7:0]                     rx_mean_power,
	input  wire logic [7:0]                     rx_energy,
	input  wire logic [6:0]                     agc_error,
	input  wire logic [7:0]                     rx_rssi,
	// Gain loop
	input  wire logic                           gain_restart,
	input  wire logic                           gain_upd_valid,
	input  wire logic [GAIN_W-1:0]              gain_upd_word,
	input  wire logic                           rf_gain_step_in,
	output logic      [GAIN_W-1:0]              if_gain_word_out,
	output logic                                rf_gain_step_out,
	// Packet events
	input  wire logic                           rx_pkt_start,
	input  wire logic                           sfd_found,
	input  wire logic                           short_preamble,
	input  wire logic                           sig_field_valid,
	input  wire logic [1:0]                     sig_rate,
	input  wire logic                           crc16_ok,
	input  wire logic                           rx_antenna,
	// Interrupt
	output logic                                irq
);
	generate
		if (GAIN_W < 2 || GAIN_W > 7) begin : g_bad_gain
			$error("bbrs_top: gain width must be 2 to 7");
		end
	endgenerate

	// Index decode of a bus address
	function automatic logic hit(input logic [bbrs_pkg::ADDR_W-1:0] a,
		input logic [7:0] idx);
		hit = (a == bbrs_pkg::byte_addr(idx));
	endfunction

	// Rate code to packet status encoding
	function automatic logic [1:0] rate_enc(input logic [1:0] r);
		if (r == bbrs_pkg::RATE_IN_1M)
			rate_enc = bbrs_pkg::RATE_ENC_1M;
		else if (r == bbrs_pkg::RATE_IN_2M)
			rate_enc = bbrs_pkg::RATE_ENC_2M;
		else
			rate_enc = bbrs_pkg::RATE_ENC_CCK;
	endfunction

	// Bus phases
	logic setup_ph;
	logic access_ph;
	logic rd_done;
	logic wr_done;
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign rd_done   = access_ph && !pwrite;
	assign wr_done   = access_ph && pwrite;

	// Address classes
	logic map_ro;
	logic map_rw;
	logic mapped;
	always_comb begin
		map_ro = hit(paddr, bbrs_pkg::IDX_CRC_LO)
			|| hit(paddr, bbrs_pkg::IDX_CRC_HI)
			|| hit(paddr, bbrs_pkg::IDX_TX_POWER)
			|| hit(paddr, bbrs_pkg::IDX_MEAN_PWR)
			|| hit(paddr, bbrs_pkg::IDX_IF_GAIN)
			|| hit(paddr, bbrs_pkg::IDX_RX_STATUS)
			|| hit(paddr, bbrs_pkg::IDX_RSSI)
			|| hit(paddr, bbrs_pkg::IDX_PKT_STAT);
		map_rw = hit(paddr, bbrs_pkg::IDX_LOCK_WIN)
			|| hit(paddr, bbrs_pkg::IDX_ED_THR)
			|| hit(paddr, bbrs_pkg::IDX_VIEW_SEL)
			|| hit(paddr, bbrs_pkg::IDX_IRQ_STAT)
			|| hit(paddr, bbrs_pkg::IDX_IRQ_MASK);
		mapped = map_ro || map_rw;
	end

	// Configuration registers
	logic [7:0] view_sel_reg;
	logic [6:0] lock_win_reg;
	logic [7:0] ed_thr_reg;

	// View select, only bit 7 has a meaning
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			view_sel_reg <= bbrs_pkg::VIEW_SEL_RST;
		end else if (wr_done && hit(paddr, bbrs_pkg::IDX_VIEW_SEL)) begin
			view_sel_reg <= pwdata[7:0];
		end
	end

	// Gain lock window magnitude
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_win_reg <= bbrs_pkg::LOCK_WIN_RST;
		end else if (wr_done && hit(paddr, bbrs_pkg::IDX_LOCK_WIN)) begin
			lock_win_reg <= pwdata[6:0];
		end
	end

	// Energy detect threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ed_thr_reg <= bbrs_pkg::ED_THR_RST;
		end else if (wr_done && hit(paddr, bbrs_pkg::IDX_ED_THR)) begin
			ed_thr_reg <= pwdata[7:0];
		end
	end

	// Captured measurements
	logic [15:0] hdr_crc_reg;
	logic [7:0]  tx_power_reg;
	logic [7:0]  mean_pwr_reg;
	logic [7:0]  rssi_reg;
	logic        rf_step_reg;

	// Header CRC, held until the next header
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_crc_reg <= 16'h0000;
		end else if (hdr_crc_valid) begin
			hdr_crc_reg <= hdr_crc;
		end
	end

	// Transmit power measurement
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_power_reg <= 8'h00;
		end else if (tx_power_valid) begin
			tx_power_reg <= tx_power;
		end
	end

	// Level measurements sampled every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mean_pwr_reg <= 8'h00;
			rssi_reg     <= 8'h00;
			rf_step_reg  <= 1'b0;
		end else begin
			mean_pwr_reg <= rx_mean_power;
			rssi_reg     <= rx_rssi;
			rf_step_reg  <= rf_gain_step_in;
		end
	end
	assign rf_gain_step_out = rf_step_reg;

	// Receive status flags
	logic       ed_flag_reg;
	logic       sem_reg;
	logic       lock_reg;
	logic       rail_flag;
	logic [6:0] agc_mag;
	logic       tx_rd;

	assign tx_rd = rd_done && hit(paddr, bbrs_pkg::IDX_TX_POWER);
	assign agc_mag = agc_error[6] ? 7'(-agc_error) : agc_error;

	// Energy detect and lock comparisons
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ed_flag_reg <= 1'b0;
			lock_reg    <= 1'b0;
		end else begin
			ed_flag_reg <= rx_energy > ed_thr_reg;
			lock_reg    <= agc_mag <= lock_win_reg;
		end
	end

	// New-value semaphore; a fresh value beats a read that clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sem_reg <= 1'b0;
		end else if (tx_power_valid) begin
			sem_reg <= 1'b1;
		end else if (tx_rd) begin
			sem_reg <= 1'b0;
		end
	end

	// Gain word and rail stop
	bbrs_gain #(
		.W     (GAIN_W),
		.RST_V (bbrs_pkg::GAIN_RST[GAIN_W-1:0])
	) u_gain (
		.pclk      (pclk),
		.presetn   (presetn),
		.restart   (gain_restart),
		.upd_valid (gain_upd_valid),
		.upd_word  (gain_upd_word),
		.word_reg  (if_gain_word_out),
		.rail_reg  (rail_flag)
	);

	// Packet status flags; the event flags clear at each new packet, rate and antenna hold
	logic [1:0] rate_reg;
	logic       sfd_reg;
	logic       short_reg;
	logic       sig_reg;
	logic       crc_ok_reg;
	logic       ant_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sfd_reg    <= 1'b0;
			short_reg  <= 1'b0;
			sig_reg    <= 1'b0;
			crc_ok_reg <= 1'b0;
		end else begin
			sfd_reg    <= sfd_found || (sfd_reg && !rx_pkt_start);
			short_reg  <= short_preamble
				|| (short_reg && !rx_pkt_start);
			sig_reg    <= sig_field_valid
				|| (sig_reg && !rx_pkt_start);
			crc_ok_reg <= crc16_ok || (crc_ok_reg && !rx_pkt_start);
		end
	end

	// Rate captured with a valid signal field
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_reg <= bbrs_pkg::RATE_ENC_1M;
		end else if (sig_field_valid) begin
			rate_reg <= rate_enc(sig_rate);
		end
	end

	// Antenna of the last packet with a good CRC
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ant_reg <= 1'b0;
		end else if (crc16_ok) begin
			ant_reg <= rx_antenna;
		end
	end

	// Interrupt events
	logic [bbrs_pkg::IRQ_N-1:0] irq_ev;
	logic [bbrs_pkg::IRQ_N-1:0] irq_stat;
	logic [bbrs_pkg::IRQ_N-1:0] irq_mask;
	logic                       ed_prev;
	logic                       rail_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ed_prev   <= 1'b0;
			rail_prev <= 1'b0;
		end else begin
			ed_prev   <= ed_flag_reg;
			rail_prev <= rail_flag;
		end
	end

	always_comb begin
		irq_ev                     = '0;
		irq_ev[bbrs_pkg::IRQ_SFD]  = sfd_found;
		irq_ev[bbrs_pkg::IRQ_SIG]  = sig_field_valid;
		irq_ev[bbrs_pkg::IRQ_CRC]  = crc16_ok;
		irq_ev[bbrs_pkg::IRQ_TXP]  = tx_power_valid;
		irq_ev[bbrs_pkg::IRQ_RAIL] = rail_flag && !rail_prev;
		irq_ev[bbrs_pkg::IRQ_ED]   = ed_flag_reg && !ed_prev;
	end

	bbrs_irq #(
		.N     (bbrs_pkg::IRQ_N),
		.M_RST (bbrs_pkg::IRQ_MASK_RST)
	) u_irq (
		.pclk       (pclk),
		.presetn    (presetn),
		.event_in   (irq_ev),
		.clr_we     (wr_done && hit(paddr, bbrs_pkg::IDX_IRQ_STAT)),
		.mask_we    (wr_done && hit(paddr, bbrs_pkg::IDX_IRQ_MASK)),
		.wdata      (pwdata[bbrs_pkg::IRQ_N-1:0]),
		.status_reg (irq_stat),
		.mask_reg   (irq_mask),
		.irq        (irq)
	);

	// Read value mux; unused bits stay zero
	logic       view_b;
	logic [7:0] rd_byte;
	logic [7:0] rxs_byte;
	logic [7:0] pkt_byte;
	assign view_b = view_sel_reg[bbrs_pkg::VIEW_SEL_BIT] == bbrs_pkg::VIEW_B;

	always_comb begin
		rxs_byte                     = 8'h00;
		rxs_byte[bbrs_pkg::RXS_ED]   = ed_flag_reg;
		rxs_byte[bbrs_pkg::RXS_SEM]  = sem_reg;
		rxs_byte[bbrs_pkg::RXS_LOCK] = lock_reg;
		rxs_byte[bbrs_pkg::RXS_RAIL] = rail_flag;
		rxs_byte[bbrs_pkg::RXS_RF]   = rf_step_reg;
		pkt_byte                     = 8'h00;
		pkt_byte[bbrs_pkg::PKT_RATE_LO +: 2] = rate_reg;
		pkt_byte[bbrs_pkg::PKT_SFD]   = sfd_reg;
		pkt_byte[bbrs_pkg::PKT_SHORT] = short_reg;
		pkt_byte[bbrs_pkg::PKT_SIG]   = sig_reg;
		pkt_byte[bbrs_pkg::PKT_CRC]   = crc_ok_reg;
		pkt_byte[bbrs_pkg::PKT_ANT]   = ant_reg;
	end

	always_comb begin
		rd_byte = 8'h00;
		if (hit(paddr, bbrs_pkg::IDX_CRC_LO))
			rd_byte = view_b ? hdr_crc_reg[7:0] : 8'h00;
		else if (hit(paddr, bbrs_pkg::IDX_CRC_HI))
			rd_byte = view_b ? hdr_crc_reg[15:8] : 8'h00;
		else if (hit(paddr, bbrs_pkg::IDX_TX_POWER))
			rd_byte = tx_power_reg;
		else if (hit(paddr, bbrs_pkg::IDX_MEAN_PWR))
			rd_byte = mean_pwr_reg;
		else if (hit(paddr, bbrs_pkg::IDX_IF_GAIN))
			rd_byte = 8'(if_gain_word_out);
		else if (hit(paddr, bbrs_pkg::IDX_RX_STATUS))
			rd_byte = rxs_byte;
		else if (hit(paddr, bbrs_pkg::IDX_RSSI))
			rd_byte = rssi_reg;
		else if (hit(paddr, bbrs_pkg::IDX_PKT_STAT))
			rd_byte = pkt_byte;
		else if (hit(paddr, bbrs_pkg::IDX_LOCK_WIN))
			rd_byte = {1'b0, lock_win_reg};
		else if (hit(paddr, bbrs_pkg::IDX_ED_THR))
			rd_byte = ed_thr_reg;
		else if (hit(paddr, bbrs_pkg::IDX_VIEW_SEL))
			rd_byte = view_sel_reg;
		else if (hit(paddr, bbrs_pkg::IDX_IRQ_STAT))
			rd_byte = 8'(irq_stat);
		else if (hit(paddr, bbrs_pkg::IDX_IRQ_MASK))
			rd_byte = 8'(irq_mask);
	end

	// Answer registered in setup, presented through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata  <= pwrite ? '0 : {24'h000000, rd_byte};
			pslverr <= !mapped;
		end
	end

	// No wait states
	assign pready = 1'b1;
endmodule // bbrs_top
`default_nettype wire

// [inc/bbrs_pkg.sv]
`default_nettype none
// Shared map, field layout and reset values of the status readback block
package bbrs_pkg;
	// Bus widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CRC_LO    = 8'h70;
	localparam logic [7:0] IDX_CRC_HI    = 8'h72;
	localparam logic [7:0] IDX_TX_POWER  = 8'h74;
	localparam logic [7:0] IDX_MEAN_PWR  = 8'h78;
	localparam logic [7:0] IDX_IF_GAIN   = 8'h7A;
	localparam logic [7:0] IDX_RX_STATUS = 8'h7C;
	localparam logic [7:0] IDX_RSSI      = 8'h7E;
	localparam logic [7:0] IDX_PKT_STAT  = 8'h80;
	localparam logic [7:0] IDX_LOCK_WIN  = 8'h28;
	localparam logic [7:0] IDX_ED_THR    = 8'h4C;
	localparam logic [7:0] IDX_VIEW_SEL  = 8'h62;
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h90;
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h92;

	// Receive status field positions
	localparam int RXS_ED   = 4;
	localparam int RXS_SEM  = 3;
	localparam int RXS_LOCK = 2;
	localparam int RXS_RAIL = 1;
	localparam int RXS_RF   = 0;

	// Packet status field positions
	localparam int PKT_RATE_LO = 6;
	localparam int PKT_SFD     = 5;
	localparam int PKT_SHORT   = 4;
	localparam int PKT_SIG     = 3;
	localparam int PKT_CRC     = 2;
	localparam int PKT_ANT     = 1;

	// Rate codes from the demodulator and their status encodings
	localparam logic [1:0] RATE_IN_1M   = 2'h0;
	localparam logic [1:0] RATE_IN_2M   = 2'h1;
	localparam logic [1:0] RATE_ENC_1M  = 2'h0;
	localparam logic [1:0] RATE_ENC_2M  = 2'h2;
	localparam logic [1:0] RATE_ENC_CCK = 2'h1;

	// View select: bit 7, zero selects the b view
	localparam int         VIEW_SEL_BIT = 7;
	localparam logic       VIEW_B       = 1'b0;

	// Interrupt bits
	localparam int IRQ_N    = 6;
	localparam int IRQ_SFD  = 0;
	localparam int IRQ_SIG  = 1;
	localparam int IRQ_CRC  = 2;
	localparam int IRQ_TXP  = 3;
	localparam int IRQ_RAIL = 4;
	localparam int IRQ_ED   = 5;

	// Reset values
	localparam logic [7:0] VIEW_SEL_RST = 8'h00;
	localparam logic [6:0] LOCK_WIN_RST = 7'h04;
	localparam logic [7:0] ED_THR_RST   = 8'h40;
	localparam logic [6:0] GAIN_RST     = 7'h40;
	localparam logic [5:0] IRQ_MASK_RST = 6'h00;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		byte_addr = {2'h0, idx, 2'h0};
	endfunction
endpackage
`default_nettype wire

// [design/bbrs_gain.sv]
`timescale 1ns/1ps
`default_nettype none
// Gain word holder; freezes once the word reaches either rail
module bbrs_gain #(
	parameter int                W     = 7,
	parameter logic [W-1:0]      RST_V = '0
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Gain loop updates
	input  wire logic         restart,
	input  wire logic         upd_valid,
	input  wire logic [W-1:0] upd_word,
	// State
	output logic      [W-1:0] word_reg,
	output logic              rail_reg
);
	localparam logic [W-1:0] RAIL_HI = '1;
	localparam logic [W-1:0] RAIL_LO = '0;

	generate
		if (W < 2) begin : g_bad_w
			$error("bbrs_gain: width below 2");
		end
	endgenerate

	// Word follows updates until a rail stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_reg <= RST_V;
		end else if (upd_valid && (!rail_reg || restart)) begin
			word_reg <= upd_word;
		end
	end

	// Rail flag, rearmed by a restart of the loop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rail_reg <= 1'b0;
		end else if (upd_valid && (!rail_reg || restart)) begin
			rail_reg <= (upd_word == RAIL_HI) || (upd_word == RAIL_LO);
		end else if (restart) begin
			rail_reg <= 1'b0;
		end
	end
endmodule // bbrs_gain
`default_nettype wire

// [design/bbrs_irq.sv]
`timescale 1ns/1ps
`default_nettype none
// Sticky event status, write-one-to-clear, with a mask and one level output
module bbrs_irq #(
	parameter int           N     = 6,
	parameter logic [N-1:0] M_RST = '0
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Events and software access
	input  wire logic [N-1:0] event_in,
	input  wire logic         clr_we,
	input  wire logic         mask_we,
	input  wire logic [N-1:0] wdata,
	// State and request
	output logic      [N-1:0] status_reg,
	output logic      [N-1:0] mask_reg,
	output logic              irq
);
	generate
		if (N < 1 || N > 32) begin : g_bad_n
			$error("bbrs_irq: event count out of range");
		end
	endgenerate

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
		end else begin
			status_reg <= (status_reg & ~({N{clr_we}} & wdata)) | event_in;
		end
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= M_RST;
		end else if (mask_we) begin
			mask_reg <= wdata;
		end
	end

	assign irq = |(status_reg & mask_reg);
endmodule // bbrs_irq
`default_nettype wire

// [bench/bbrs_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host controller model: a plain bus master
module bbrs_host (
	// Clock
	input  wire logic        pclk,
	// Request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	// Answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// One transfer, held until pready is seen high
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;  // Released bus shows no stale address
		pwdata <= ~d;
	endtask
endmodule // bbrs_host
`default_nettype wire

// [bench/bbrs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level relations of the readback block
module bbrs_props #(
	parameter int GAIN_W = 7
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// Register bus
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       prdata,
	input  wire logic              pslverr,
	// Measurements
	input  wire logic              tx_power_valid,
	input  wire logic [7:0]        tx_power,
	input  wire logic [7:0]        rx_rssi,
	// Gain loop
	input  wire logic              gain_restart,
	input  wire logic              gain_upd_valid,
	input  wire logic [GAIN_W-1:0] gain_upd_word,
	input  wire logic              rf_gain_step_in,
	input  wire logic [GAIN_W-1:0] if_gain_word_out,
	input  wire logic              rf_gain_step_out
);
	// Byte addresses of watched registers
	localparam logic [11:0] A_TXP = {2'h0, bbrs_pkg::IDX_TX_POWER, 2'h0};
	localparam logic [11:0] A_IFG = {2'h0, bbrs_pkg::IDX_IF_GAIN, 2'h0};
	localparam logic [11:0] A_RSS = {2'h0, bbrs_pkg::IDX_RSSI, 2'h0};
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Setup cycle of a transfer
	logic       setup;
	assign setup = psel && !penable;
	// Last transmit power value offered
	logic [7:0] txp_last;
	logic       txp_have;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txp_have <= 1'b0;
			txp_last <= 8'h00;
		end else if (tx_power_valid) begin
			txp_have <= 1'b1;
			txp_last <= tx_power;
		end
	end
	a_pad_zero: assert property (psel && penable && !pwrite |->
		prdata[31:8] == 24'h0) else $error("upper read bits set");
	a_err_misalign: assert property (setup && paddr[1:0] != 2'h0
		|=> pslverr) else $error("misaligned access not refused");
	a_ok_txp: assert property (setup && paddr == A_TXP |=> !pslverr)
		else $error("power read refused");
	a_txp_read: assert property (setup && paddr == A_TXP && txp_have
		&& !tx_power_valid |=> prdata[7:0] == txp_last)
		else $error("power readback wrong");
	a_ifg_read: assert property (setup && paddr == A_IFG |=>
		prdata[7:0] == 8'($past(if_gain_word_out)))
		else $error("gain word readback wrong");
	a_rssi_read: assert property (setup && paddr == A_RSS &&
		$stable(rx_rssi) |=> prdata[7:0] == $past(rx_rssi))
		else $error("strength readback wrong");
	a_rf_mirror: assert property (presetn |=>
		rf_gain_step_out == $past(rf_gain_step_in))
		else $error("gain step output not mirrored");
	a_gain_hold: assert property (!gain_upd_valid && !gain_restart
		|=> $stable(if_gain_word_out)) else $error("gain word moved");
	a_gain_load: assert property (gain_upd_valid && gain_restart |=>
		if_gain_word_out == $past(gain_upd_word))
		else $error("restart update not taken");
endmodule // bbrs_props
bind bbrs_top bbrs_props #(.GAIN_W(GAIN_W)) chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.tx_power_valid(tx_power_valid), .tx_power(tx_power),
	.rx_rssi(rx_rssi), .gain_restart(gain_restart),
	.gain_upd_valid(gain_upd_valid), .gain_upd_word(gain_upd_word),
	.rf_gain_step_in(rf_gain_step_in), .if_gain_word_out(if_gain_word_out),
	.rf_gain_step_out(rf_gain_step_out)
);
`default_nettype wire

// [bench/bbrs_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bbrs_top_tb_top;
	// Table row: datapath levels, register read, value expected
	typedef struct {
		logic [7:0] ene;
		logic [6:0] agc;
		logic       rf;
		logic [7:0] lvl;
		logic [7:0] idx;
		logic [7:0] exp;
	} bbrs_row_t;
	// Design inputs, idle at time zero
	logic        pclk = 1'b0, presetn = 1'b0, rx_antenna = 1'b0;
	logic        hdr_crc_valid = 1'b0, tx_power_valid = 1'b0;
	logic        gain_restart = 1'b0, gain_upd_valid = 1'b0;
	logic        rf_gain_step_in = 1'b0, rx_pkt_start = 1'b0;
	logic        sfd_found = 1'b0, short_preamble = 1'b0;
	logic        sig_field_valid = 1'b0, crc16_ok = 1'b0;
	logic [1:0]  sig_rate = 2'h0;
	logic [6:0]  agc_error = 7'h00, gain_upd_word = 7'h00;
	logic [7:0]  tx_power = 8'h00, rx_mean_power = 8'h00;
	logic [7:0]  rx_energy = 8'h00, rx_rssi = 8'h00;
	logic [15:0] hdr_crc = 16'h0000;
	// Bus and design outputs
	logic        psel, penable, pwrite, pready, pslverr;
	logic        rf_gain_step_out, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [6:0]  if_gain_word_out;
	int          err_total = 0, checks_done = 0;
	// Rate encodings by demodulator code
	logic [1:0]  enc [4] = '{2'h0, 2'h2, 2'h1, 2'h1};
	bbrs_row_t   rows [11] = '{
		'{8'h41, 7'h03, 1'b1, 8'hA5, bbrs_pkg::IDX_RX_STATUS, 8'h15},
		'{8'h40, 7'h05, 1'b0, 8'h5A, bbrs_pkg::IDX_RX_STATUS, 8'h00},
		'{8'h40, 7'h7C, 1'b0, 8'h5A, bbrs_pkg::IDX_RX_STATUS, 8'h04},
		'{8'h40, 7'h7B, 1'b1, 8'hA5, bbrs_pkg::IDX_RX_STATUS, 8'h01},
		'{8'h40, 7'h7B, 1'b1, 8'hA5, bbrs_pkg::IDX_MEAN_PWR, 8'hA5},
		'{8'h40, 7'h7B, 1'b1, 8'h3C, bbrs_pkg::IDX_RSSI, 8'h3C},
		'{8'h40, 7'h7B, 1'b1, 8'h3C, bbrs_pkg::IDX_IF_GAIN, 8'h40},
		'{8'h40, 7'h7B, 1'b1, 8'h3C, bbrs_pkg::IDX_ED_THR, 8'h40},
		'{8'h40, 7'h7B, 1'b1, 8'h3C, bbrs_pkg::IDX_LOCK_WIN, 8'h04},
		'{8'h40, 7'h7B, 1'b1, 8'h3C, bbrs_pkg::IDX_VIEW_SEL, 8'h00},
		'{8'h40, 7'h7B, 1'b1, 8'h3C, bbrs_pkg::IDX_IRQ_MASK, 8'h00}};
	// Design and host
	bbrs_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .hdr_crc_valid, .hdr_crc,
		.tx_power_valid, .tx_power, .rx_mean_power, .rx_energy, .agc_error,
		.rx_rssi, .gain_restart, .gain_upd_valid, .gain_upd_word,
		.rf_gain_step_in, .if_gain_word_out, .rf_gain_step_out,
		.rx_pkt_start, .sfd_found, .short_preamble, .sig_field_valid,
		.sig_rate, .crc16_ok, .rx_antenna, .irq);
	bbrs_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);
	// 100 MHz clock
	always #5 pclk = ~pclk;
	function automatic logic [11:0] ba(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Read compares error flag and full word at once
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b0, ba(idx), 32'h0, q, e);
		check({e, q}, {25'h0, exp});
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		host.xfer(1'b1, ba(idx), {24'h0, d}, q, e);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard
	initial begin
		tick(4000);
		err_total++;
		wrap_up();
	end
	initial begin
		logic [31:0] q;
		logic        e;
		tick(6);
		presetn <= 1'b1;
		// Table of level inputs and register reads
		foreach (rows[i]) begin
			rx_energy <= rows[i].ene;
			agc_error <= rows[i].agc;
			rf_gain_step_in <= rows[i].rf;
			rx_mean_power <= rows[i].lvl;
			rx_rssi <= rows[i].lvl;
			tick(3);
			rdchk(rows[i].idx, rows[i].exp);
		end
		// Capture header CRC and most negative power together
		hdr_crc <= 16'hC3A5;
		tx_power <= 8'h80;
		hdr_crc_valid <= 1'b1;
		tx_power_valid <= 1'b1;
		tick(1);
		hdr_crc_valid <= 1'b0;
		tx_power_valid <= 1'b0;
		rdchk(bbrs_pkg::IDX_RX_STATUS, 8'h09);
		rdchk(bbrs_pkg::IDX_CRC_LO, 8'hA5);
		rdchk(bbrs_pkg::IDX_CRC_HI, 8'hC3);
		rdchk(bbrs_pkg::IDX_TX_POWER, 8'h80);
		rdchk(bbrs_pkg::IDX_RX_STATUS, 8'h01);
		// Other view hides the CRC only
		wr(bbrs_pkg::IDX_VIEW_SEL, 8'h80);
		rdchk(bbrs_pkg::IDX_CRC_LO, 8'h00);
		rdchk(bbrs_pkg::IDX_CRC_HI, 8'h00);
		rdchk(bbrs_pkg::IDX_TX_POWER, 8'h80);
		wr(bbrs_pkg::IDX_VIEW_SEL, 8'h00);
		wr(bbrs_pkg::IDX_CRC_LO, 8'hFF);
		rdchk(bbrs_pkg::IDX_CRC_LO, 8'hA5);
		host.xfer(1'b0, 12'h1C1, 32'h0, q, e);
		check(33'(e), 33'h1);
		host.xfer(1'b0, ba(8'h71), 32'h0, q, e);
		check(33'(e), 33'h1);
		// Rail hit freezes the word; back-to-back update ignored
		gain_upd_word <= 7'h7F;
		gain_upd_valid <= 1'b1;
		tick(1);
		gain_upd_word <= 7'h10;
		tick(1);
		gain_upd_valid <= 1'b0;
		rdchk(bbrs_pkg::IDX_RX_STATUS, 8'h03);
		rdchk(bbrs_pkg::IDX_IF_GAIN, 8'h7F);
		gain_restart <= 1'b1;
		gain_upd_valid <= 1'b1;
		tick(1);
		gain_restart <= 1'b0;
		gain_upd_valid <= 1'b0;
		rdchk(bbrs_pkg::IDX_RX_STATUS, 8'h01);
		rdchk(bbrs_pkg::IDX_IF_GAIN, 8'h10);
		// Every rate code, preamble kind and antenna
		for (int k = 0; k < 4; k++) begin
			rx_pkt_start <= 1'b1;
			tick(1);
			rx_pkt_start <= 1'b0;
			sfd_found <= 1'b1;
			short_preamble <= k[0];
			sig_field_valid <= 1'b1;
			sig_rate <= k[1:0];
			crc16_ok <= 1'b1;
			rx_antenna <= k[1];
			tick(1);
			sfd_found <= 1'b0;
			short_preamble <= 1'b0;
			sig_field_valid <= 1'b0;
			crc16_ok <= 1'b0;
			rdchk(bbrs_pkg::IDX_PKT_STAT,
				{enc[k], 2'b11 ^ {1'b0, ~k[0]}, 2'b11, k[1], 1'b0});
		end
		rx_pkt_start <= 1'b1;
		tick(1);
		rx_pkt_start <= 1'b0;
		rdchk(bbrs_pkg::IDX_PKT_STAT, 8'h42);
		// Sticky events gated by the mask
		check(33'(irq), 33'h0);
		wr(bbrs_pkg::IDX_IRQ_MASK, 8'h20);
		tick(1);
		check(33'(irq), 33'h1);
		wr(bbrs_pkg::IDX_IRQ_STAT, 8'h20);
		tick(1);
		check(33'(irq), 33'h0);
		rdchk(bbrs_pkg::IDX_IRQ_STAT, 8'h1F);
		// Written thresholds take effect; mid-run reset restores them
		wr(bbrs_pkg::IDX_ED_THR, 8'h30);
		wr(bbrs_pkg::IDX_LOCK_WIN, 8'h05);
		rdchk(bbrs_pkg::IDX_RX_STATUS, 8'h15);
		presetn <= 1'b0;
		tick(2);
		check(33'(if_gain_word_out), 33'h040);
		check({1'b0, prdata}, 33'h0);
		check(33'({pslverr, rf_gain_step_out, irq}), 33'h0);
		presetn <= 1'b1;
		rdchk(bbrs_pkg::IDX_RX_STATUS, 8'h01);
		rdchk(bbrs_pkg::IDX_IF_GAIN, 8'h40);
		wrap_up();
	end
endmodule // bbrs_top_tb_top
`default_nettype wire
